// ---- verilog/ccr_pkg.sv ----
`default_nettype none
// Shared constants of the channel calibration register bank
package ccr_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_GLOBAL_HPF = 6'h08;
    localparam logic [5:0] IDX_CH0_SETUP = 6'h09;
    localparam logic [5:0] IDX_CH0_OFF_HI = 6'h0a;
    localparam logic [5:0] IDX_CH0_OFF_LO = 6'h0b;
    localparam logic [5:0] IDX_CH0_GAIN_HI = 6'h0c;
    localparam logic [5:0] IDX_CH0_GAIN_LO = 6'h0d;
    localparam logic [5:0] IDX_CH1_SETUP = 6'h0e;
    localparam logic [5:0] IDX_CH1_OFF_HI = 6'h0f;
    localparam logic [5:0] IDX_CH1_OFF_LO = 6'h10;
    localparam logic [5:0] IDX_CH1_GAIN_HI = 6'h11;
    localparam logic [5:0] IDX_CH1_GAIN_LO = 6'h12;
    localparam logic [5:0] IDX_CH2_SETUP = 6'h13;
    localparam logic [5:0] IDX_CH2_OFF_HI = 6'h14;
    localparam logic [5:0] IDX_STATUS = 6'h20;
    // Setup word field positions
    localparam int PHASE_MSB = 15;
    localparam int PHASE_LSB = 6;
    localparam int BYPASS_BIT = 2;
    localparam int ROUTE_MSB = 1;
    // Low trim registers keep their byte in bits 15:8
    localparam int LOW_LSB = 8;
    // Global filter setting in bits 3:0
    localparam int GHPF_MSB = 3;
    // Reset values
    localparam logic [15:0] GAIN_HI_RST = 16'h8000;
    localparam logic [15:0] ZERO_RST = 16'h0000;
    // Input routes
    localparam logic [1:0] ROUTE_OWN_PINS = 2'h0;
    localparam logic [1:0] ROUTE_SHORTED = 2'h1;
    localparam logic [1:0] ROUTE_TEST_POS = 2'h2;
    localparam logic [1:0] ROUTE_TEST_NEG = 2'h3;
    // Gain word is 1.23 fixed point; unity is bit 23
    localparam int GAIN_FRAC = 23;
    localparam logic [23:0] GAIN_UNITY = 24'h800000;
    localparam logic [23:0] SAT_POS = 24'h7fffff;
    localparam logic [23:0] SAT_NEG = 24'h800000;
endpackage
`default_nettype wire

// ---- verilog/ccr_chan_trim.sv ----
`timescale 1ns/1ps
`default_nettype none
// Applies offset then gain correction to one channel's samples
module ccr_chan_trim (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sample_valid,
    input wire logic [23:0] sample,
    input wire logic [23:0] offset,
    input wire logic [23:0] gain,
    output logic result_valid,
    output logic [23:0] result,
    output logic saturated
);
    // Whole state of the channel datapath
    typedef struct packed {
        logic valid;
        logic sat;
        logic [23:0] data;
    } ccr_trim_type;

    ccr_trim_type st; // Registered state
    ccr_trim_type next_st; // Next state

    // Offset add, gain multiply, saturate
    always_comb begin
        logic signed [24:0] sum;
        logic signed [49:0] prod;
        sum = '0;
        prod = '0;
        next_st = st;
        next_st.valid = sample_valid;
        if (sample_valid) begin
            sum = $signed({sample[23], sample}) + $signed({offset[23], offset});
            prod = sum * $signed({1'b0, gain});
            // Fits only if the bits above the result agree with its sign
            if (prod[49:46] == {4{prod[46]}}) begin
                next_st.data = prod[46:ccr_pkg::GAIN_FRAC];
                next_st.sat = 1'b0;
            end else begin
                next_st.data = prod[49] ? ccr_pkg::SAT_NEG : ccr_pkg::SAT_POS;
                next_st.sat = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign result_valid = st.valid;
    assign result = st.data;
    assign saturated = st.sat;

    property p_unity_passes;
        @(posedge pclk) disable iff (!presetn)
        sample_valid && gain == ccr_pkg::GAIN_UNITY && offset == 24'h000000
        |=> result_valid && result == $past(sample) && !saturated;
    endproperty
    a_unity_passes: assert property (p_unity_passes) else $error("unity trim altered sample");

    property p_offset_adds;
        @(posedge pclk) disable iff (!presetn)
        sample_valid && gain == ccr_pkg::GAIN_UNITY && sample == 24'h000000 && !offset[23]
        |=> result == $past(offset);
    endproperty
    a_offset_adds: assert property (p_offset_adds) else $error("offset not added");
endmodule
`default_nettype wire

// ---- verilog/ccr_regbank.sv ----
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ccr_regbank (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ch0_sample_valid,
    input wire logic [23:0] ch0_sample,
    output logic ch0_result_valid,
    output logic [23:0] ch0_result,
    output logic [9:0] ch0_phase_delay,
    output logic [3:0] ch0_hpf_setting,
    output logic [1:0] ch0_input_route,
    input wire logic ch1_sample_valid,
    input wire logic [23:0] ch1_sample,
    output logic ch1_result_valid,
    output logic [23:0] ch1_result,
    output logic [9:0] ch1_phase_delay,
    output logic [3:0] ch1_hpf_setting,
    output logic [1:0] ch1_input_route,
    input wire logic ch2_sample_valid,
    input wire logic [23:0] ch2_sample,
    output logic ch2_result_valid,
    output logic [23:0] ch2_result,
    output logic [9:0] ch2_phase_delay,
    output logic [3:0] ch2_hpf_setting,
    output logic [1:0] ch2_input_route
);
    // Whole state of the bank and its bus slave
    typedef struct packed {
        logic ack;
        logic err;
        logic [15:0] rdata;
        logic [3:0] global_hpf;
        logic [2:0][9:0] phase;
        logic [2:0] bypass;
        logic [2:0][1:0] route;
        logic [2:0][15:0] off_hi;
        logic [1:0][7:0] off_lo;
        logic [1:0][15:0] gain_hi;
        logic [1:0][7:0] gain_lo;
    } ccr_bank_type;

    // Reset image: gain high words at unity, all else zero
    localparam ccr_bank_type BANK_RST = '{
        gain_hi: {2{ccr_pkg::GAIN_HI_RST}},
        default: '0
    };

    // Per-channel index tables
    localparam logic [2:0][5:0] SETUP_IDX = {ccr_pkg::IDX_CH2_SETUP,
        ccr_pkg::IDX_CH1_SETUP, ccr_pkg::IDX_CH0_SETUP};
    localparam logic [2:0][5:0] OFF_HI_IDX = {ccr_pkg::IDX_CH2_OFF_HI,
        ccr_pkg::IDX_CH1_OFF_HI, ccr_pkg::IDX_CH0_OFF_HI};
    localparam logic [1:0][5:0] OFF_LO_IDX = {ccr_pkg::IDX_CH1_OFF_LO,
        ccr_pkg::IDX_CH0_OFF_LO};
    localparam logic [1:0][5:0] GAIN_HI_IDX = {ccr_pkg::IDX_CH1_GAIN_HI,
        ccr_pkg::IDX_CH0_GAIN_HI};
    localparam logic [1:0][5:0] GAIN_LO_IDX = {ccr_pkg::IDX_CH1_GAIN_LO,
        ccr_pkg::IDX_CH0_GAIN_LO};

    ccr_bank_type st; // Registered state
    ccr_bank_type next_st; // Next state

    logic [5:0] idx; // Word index of the access
    logic aligned; // Byte address is word aligned
    logic [15:0] rd_word; // Read mux output
    logic hit; // Address maps to a register
    logic [2:0] sat; // Last result saturated, per channel
    logic [2:0][23:0] off24; // Joined offset words
    logic [2:0][23:0] gain24; // Joined gain words
    logic [2:0] s_valid; // Sample strobes
    logic [2:0][23:0] s_data; // Sample words
    logic [2:0] r_valid; // Result strobes
    logic [2:0][23:0] r_data; // Result words
    logic [2:0][3:0] hpf_eff; // Effective filter setting

    // Merge a write into a 16-bit word under the two low byte strobes
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0] strb);
        logic [15:0] mask;
        mask = {{8{strb[1]}}, {8{strb[0]}}};
        return (old & ~mask) | (wd & mask);
    endfunction

    // Assemble a setup word; bits 5:3 read as zero
    function automatic logic [15:0] setup_word(input logic [9:0] ph,
                                               input logic byp,
                                               input logic [1:0] rt);
        return {ph, 3'h0, byp, rt};
    endfunction

    assign idx = paddr[7:2];
    assign aligned = (paddr[1:0] == 2'h0);

    // Read decode, status and every mapped register
    always_comb begin
        rd_word = 16'h0000;
        hit = 1'b1;
        if (!aligned) begin
            hit = 1'b0;
        end else if (idx == ccr_pkg::IDX_GLOBAL_HPF) begin
            rd_word = {12'h000, st.global_hpf};
        end else if (idx == ccr_pkg::IDX_STATUS) begin
            rd_word = {13'h0, sat};
        end else begin
            hit = 1'b0;
            for (int k = 0; k < 3; k++) begin
                if (idx == SETUP_IDX[k]) begin
                    rd_word = setup_word(st.phase[k], st.bypass[k], st.route[k]);
                    hit = 1'b1;
                end else if (idx == OFF_HI_IDX[k]) begin
                    rd_word = st.off_hi[k];
                    hit = 1'b1;
                end else if (k < 2 && idx == OFF_LO_IDX[k[0]]) begin
                    rd_word = {st.off_lo[k[0]], 8'h00};
                    hit = 1'b1;
                end else if (k < 2 && idx == GAIN_HI_IDX[k[0]]) begin
                    rd_word = st.gain_hi[k[0]];
                    hit = 1'b1;
                end else if (k < 2 && idx == GAIN_LO_IDX[k[0]]) begin
                    rd_word = {st.gain_lo[k[0]], 8'h00};
                    hit = 1'b1;
                end
            end
        end
    end

    // Bus slave and register updates
    always_comb begin
        logic [15:0] w;
        w = 16'h0000;
        next_st = st;
        // One wait state: data is captured on the same edge that raises pready
        next_st.ack = psel && penable && !st.ack;
        if (psel && penable && !st.ack) begin
            next_st.rdata = pwrite ? 16'h0000 : rd_word;
            next_st.err = !hit;
        end
        // Writes land on the completing edge only
        if (psel && penable && st.ack && pwrite && hit) begin
            if (idx == ccr_pkg::IDX_GLOBAL_HPF) begin
                w = merge16({12'h000, st.global_hpf}, pwdata[15:0], pstrb[1:0]);
                next_st.global_hpf = w[ccr_pkg::GHPF_MSB:0];
            end
            for (int k = 0; k < 3; k++) begin
                if (idx == SETUP_IDX[k]) begin
                    w = merge16(setup_word(st.phase[k], st.bypass[k], st.route[k]),
                                pwdata[15:0], pstrb[1:0]);
                    next_st.phase[k] = w[ccr_pkg::PHASE_MSB:ccr_pkg::PHASE_LSB];
                    next_st.bypass[k] = w[ccr_pkg::BYPASS_BIT];
                    next_st.route[k] = w[ccr_pkg::ROUTE_MSB:0];
                end else if (idx == OFF_HI_IDX[k]) begin
                    next_st.off_hi[k] = merge16(st.off_hi[k], pwdata[15:0], pstrb[1:0]);
                end else if (k < 2 && idx == OFF_LO_IDX[k[0]]) begin
                    // Reserved low byte ignores writes
                    w = merge16({st.off_lo[k[0]], 8'h00}, pwdata[15:0], pstrb[1:0]);
                    next_st.off_lo[k[0]] = w[15:ccr_pkg::LOW_LSB];
                end else if (k < 2 && idx == GAIN_HI_IDX[k[0]]) begin
                    next_st.gain_hi[k[0]] = merge16(st.gain_hi[k[0]], pwdata[15:0], pstrb[1:0]);
                end else if (k < 2 && idx == GAIN_LO_IDX[k[0]]) begin
                    w = merge16({st.gain_lo[k[0]], 8'h00}, pwdata[15:0], pstrb[1:0]);
                    next_st.gain_lo[k[0]] = w[15:ccr_pkg::LOW_LSB];
                end
            end
        end
    end

    // State register; reset image sets every documented default
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= BANK_RST;
        end else begin
            st <= next_st;
        end
    end

    // Bus outputs
    assign pready = st.ack;
    assign pslverr = st.ack && st.err;
    assign prdata = {16'h0000, st.rdata};

    // Join halves; channel 2 lower words are not mapped and sit at reset
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            off24[k] = {st.off_hi[k], st.off_lo[k]};
            gain24[k] = {st.gain_hi[k], st.gain_lo[k]};
        end
        off24[2] = {st.off_hi[2], ccr_pkg::ZERO_RST[7:0]};
        gain24[2] = {ccr_pkg::GAIN_HI_RST, ccr_pkg::ZERO_RST[7:0]};
        // Channel bit clear hands control to the global setting
        for (int k = 0; k < 3; k++) begin
            hpf_eff[k] = st.bypass[k] ? 4'h0 : st.global_hpf;
        end
    end

    assign s_valid = {ch2_sample_valid, ch1_sample_valid, ch0_sample_valid};
    assign s_data = {ch2_sample, ch1_sample, ch0_sample};

    // One correction datapath per channel
    for (genvar g = 0; g < 3; g++) begin : g_chan
        ccr_chan_trim u_trim (
            .pclk(pclk),
            .presetn(presetn),
            .sample_valid(s_valid[g]),
            .sample(s_data[g]),
            .offset(off24[g]),
            .gain(gain24[g]),
            .result_valid(r_valid[g]),
            .result(r_data[g]),
            .saturated(sat[g])
        );
    end

    // Channel outputs
    assign ch0_result_valid = r_valid[0];
    assign ch0_result = r_data[0];
    assign ch0_phase_delay = st.phase[0];
    assign ch0_hpf_setting = hpf_eff[0];
    assign ch0_input_route = st.route[0];
    assign ch1_result_valid = r_valid[1];
    assign ch1_result = r_data[1];
    assign ch1_phase_delay = st.phase[1];
    assign ch1_hpf_setting = hpf_eff[1];
    assign ch1_input_route = st.route[1];
    assign ch2_result_valid = r_valid[2];
    assign ch2_result = r_data[2];
    assign ch2_phase_delay = st.phase[2];
    assign ch2_hpf_setting = hpf_eff[2];
    assign ch2_input_route = st.route[2];

    // Checks
    property p_off_hi_write;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && paddr == {ccr_pkg::IDX_CH1_OFF_HI, 2'h0}
        && pstrb[1:0] == 2'h3 |=> off24[1][23:8] == $past(pwdata[15:0]);
    endproperty
    a_off_hi_write: assert property (p_off_hi_write) else $error("offset high not stored");

    property p_off_lo_read;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && !pwrite && paddr == {ccr_pkg::IDX_CH0_OFF_LO, 2'h0}
        |=> pready && prdata[7:0] == 8'h00 && prdata[15:8] == off24[0][7:0];
    endproperty
    a_off_lo_read: assert property (p_off_lo_read) else $error("offset low read wrong");

    property p_gain_reset;
        @(posedge pclk) disable iff (!presetn)
        $past(!presetn) |-> gain24[0] == ccr_pkg::GAIN_UNITY && gain24[1] == ccr_pkg::GAIN_UNITY;
    endproperty
    a_gain_reset: assert property (p_gain_reset) else $error("gain not unity after reset");

    property p_gain_lo_write;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && paddr == {ccr_pkg::IDX_CH1_GAIN_LO, 2'h0}
        && pstrb[1] |=> gain24[1][7:0] == $past(pwdata[15:8]);
    endproperty
    a_gain_lo_write: assert property (p_gain_lo_write) else $error("gain low not stored");

    property p_setup_read;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && !pwrite && paddr == {ccr_pkg::IDX_CH1_SETUP, 2'h0}
        |=> prdata[5:3] == 3'h0 && prdata[15:6] == ch1_phase_delay;
    endproperty
    a_setup_read: assert property (p_setup_read) else $error("setup read wrong");

    property p_bypass;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && paddr == {ccr_pkg::IDX_CH1_SETUP, 2'h0}
        && pstrb[0] && pwdata[2] |=> ch1_hpf_setting == 4'h0 ##1 ch1_hpf_setting == 4'h0;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass did not hold filter off");

    property p_route;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && paddr == {ccr_pkg::IDX_CH1_SETUP, 2'h0}
        && pstrb[0] |=> ch1_input_route == $past(pwdata[1:0]);
    endproperty
    a_route: assert property (p_route) else $error("route not applied");

    property p_zero_reset;
        @(posedge pclk) disable iff (!presetn)
        $past(!presetn) |-> off24 == '0 && ch0_input_route == ccr_pkg::ROUTE_OWN_PINS
        && ch1_phase_delay == 10'h000 && gain24[0][7:0] == 8'h00;
    endproperty
    a_zero_reset: assert property (p_zero_reset) else $error("reset values wrong");

    property p_global_hpf;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && paddr == {ccr_pkg::IDX_GLOBAL_HPF, 2'h0}
        && pstrb[0] && !ch2_input_route[0] |=> ch2_hpf_setting == (st.bypass[2] ? 4'h0 : $past(pwdata[3:0]));
    endproperty
    a_global_hpf: assert property (p_global_hpf) else $error("global filter setting lost");

    // Full write of a gain high word reaches the joined value
    property p_gain_hi_write;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && paddr == {ccr_pkg::IDX_CH0_GAIN_HI, 2'h0}
        && pstrb[1:0] == 2'h3 |=> gain24[0][23:8] == $past(pwdata[15:0]);
    endproperty
    a_gain_hi_write: assert property (p_gain_hi_write) else $error("gain high not stored");

    // Upper byte lane of an offset low write holds offset bits 7:0
    property p_off_lo_write;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && paddr == {ccr_pkg::IDX_CH0_OFF_LO, 2'h0}
        && pstrb[1] |=> off24[0][7:0] == $past(pwdata[15:8]);
    endproperty
    a_off_lo_write: assert property (p_off_lo_write) else $error("offset low not stored");

    // Every channel 1 sample yields exactly one result strobe a cycle later
    property p_result_strobe;
        @(posedge pclk) disable iff (!presetn)
        ch1_result_valid == $past(ch1_sample_valid);
    endproperty
    a_result_strobe: assert property (p_result_strobe) else $error("result strobe wrong");

    // Status read returns the saturation flags seen at capture
    property p_status_read;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pready && !pwrite && paddr == {ccr_pkg::IDX_STATUS, 2'h0}
        |=> pready && prdata[2:0] == $past(sat);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_answer_time;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready;
    endproperty
    a_answer_time: assert property (p_answer_time) else $error("slave answer late");
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the calibration register bank
module tb_top;
    logic pclk, presetn, psel, penable, pwrite; // Clock, reset, APB controls
    logic [7:0] paddr; // Byte address
    logic [31:0] pwdata, prdata; // Bus data
    logic [3:0] pstrb; // Byte strobes
    logic pready, pslverr; // Slave answer
    logic [2:0] sv, rv; // Sample and result valids per channel
    logic [23:0] smp[3], res[3]; // Samples in, corrected results out
    logic [9:0] ph[3]; // Exported phase delays
    logic [3:0] hp[3]; // Exported filter settings
    logic [1:0] rt[3]; // Exported input routes
    logic [15:0] mdl[64]; // Register model by word index
    logic [31:0] seed; // Pseudo-random state
    logic [2:0] sx; // Expected saturation flags of the last pulse
    int miscompares, check_count; // Error and comparison counters

    ccr_regbank DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ch0_sample_valid(sv[0]), .ch0_sample(smp[0]), .ch0_result_valid(rv[0]), .ch0_result(res[0]),
        .ch0_phase_delay(ph[0]), .ch0_hpf_setting(hp[0]), .ch0_input_route(rt[0]),
        .ch1_sample_valid(sv[1]), .ch1_sample(smp[1]), .ch1_result_valid(rv[1]), .ch1_result(res[1]),
        .ch1_phase_delay(ph[1]), .ch1_hpf_setting(hp[1]), .ch1_input_route(rt[1]),
        .ch2_sample_valid(sv[2]), .ch2_sample(smp[2]), .ch2_result_valid(rv[2]), .ch2_result(res[2]),
        .ch2_phase_delay(ph[2]), .ch2_hpf_setting(hp[2]), .ch2_input_route(rt[2]));

    // Free-running 250 MHz clock
    always #2 pclk = ~pclk;

    // Fibonacci-style feedback step
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Writable bits of each word
    function automatic logic [15:0] wmask(input logic [5:0] i);
        case (i)
            6'h08: return 16'h000f;
            6'h09, 6'h0e, 6'h13: return 16'hffc7;
            6'h0a, 6'h0c, 6'h0f, 6'h11, 6'h14: return 16'hffff;
            6'h0b, 6'h0d, 6'h10, 6'h12: return 16'hff00;
            default: return 16'h0000;
        endcase
    endfunction

    // Offset then gain, floor divide, saturate
    function automatic logic [23:0] corr(input logic [23:0] s, input logic [23:0] off, input logic [23:0] g);
        longint p;
        p = (longint'(signed'(s)) + longint'(signed'(off))) * longint'({40'h0, g});
        p = p >>> 23;
        if (p > 64'sd8388607) return 24'h7fffff;
        if (p < -64'sd8388608) return 24'h800000;
        return p[23:0];
    endfunction

    // Corrected value leaves the 24-bit signed range
    function automatic logic ovf(input logic [23:0] s, input logic [23:0] off, input logic [23:0] g);
        longint p;
        p = ((longint'(signed'(s)) + longint'(signed'(off))) * longint'({40'h0, g})) >>> 23;
        return p > 64'sd8388607 || p < -64'sd8388608;
    endfunction

    // Verdict and end of run
    task automatic results;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Single comparison point
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] wd, input logic [3:0] st,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {seed[31:16], wd};
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            miscompares++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        seed = lfsr(seed);
    endtask

    // Register write with model update
    task automatic wr(input logic [5:0] i, input logic [15:0] d, input logic [3:0] st);
        logic [31:0] rd;
        logic er;
        logic [15:0] m;
        m = wmask(i) & {{8{st[1]}}, {8{st[0]}}};
        apb(1'b1, {i, 2'b00}, d, st, rd, er);
        check(er, 0);
        mdl[i] = (mdl[i] & ~m) | (d & m);
    endtask

    // Register read against the model
    task automatic rdc(input logic [5:0] i);
        logic [31:0] rd;
        logic er;
        apb(1'b0, {i, 2'b00}, 16'h0, 4'h0, rd, er);
        check(er, 0);
        check(rd, {16'h0, mdl[i]});
    endtask

    // Exported setup fields of all channels
    task automatic chk_ports;
        logic [5:0] s;
        // Let the last completed write land first
        @(negedge pclk);
        for (int c = 0; c < 3; c++) begin
            s = 6'(9 + 5 * c);
            check(ph[c], mdl[s][15:6]);
            check(rt[c], mdl[s][1:0]);
            check(hp[c], mdl[s][2] ? 4'h0 : mdl[8][3:0]);
        end
    endtask

    // Pulse all channels and compare corrected results
    task automatic pulse(input logic [23:0] s0, input logic [23:0] s1, input logic [23:0] s2);
        logic [23:0] e[3];
        logic [23:0] s[3];
        logic [23:0] ofs[3];
        logic [23:0] gn[3];
        s = '{s0, s1, s2};
        for (int c = 0; c < 2; c++) begin
            ofs[c] = {mdl[10 + 5 * c], mdl[11 + 5 * c][15:8]};
            gn[c] = {mdl[12 + 5 * c], mdl[13 + 5 * c][15:8]};
        end
        ofs[2] = {mdl[20], 8'h00};
        gn[2] = 24'h800000;
        for (int c = 0; c < 3; c++) begin
            e[c] = corr(s[c], ofs[c], gn[c]);
            sx[c] = ovf(s[c], ofs[c], gn[c]);
        end
        @(posedge pclk);
        sv <= 3'b111;
        smp[0] <= s0;
        smp[1] <= s1;
        smp[2] <= s2;
        @(posedge pclk);
        sv <= 3'b000;
        #1;
        for (int c = 0; c < 3; c++) begin
            check(rv[c], 1);
            check(res[c], e[c]);
        end
    endtask

    // Main sequence
    initial begin
        logic [31:0] rd;
        logic er;
        logic [23:0] g, o;
        pclk = 0;
        presetn = 0;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        sv = 3'b000;
        smp = '{24'h0, 24'h0, 24'h0};
        seed = 32'h0754;
        miscompares = 0;
        check_count = 0;
        foreach (mdl[i]) mdl[i] = (i == 12 || i == 17) ? ccr_pkg::GAIN_HI_RST : ccr_pkg::ZERO_RST;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and default routing
        for (int i = 8; i <= 20; i++) rdc(6'(i));
        chk_ports();
        // Random full writes, reserved bits must read zero
        repeat (3) begin
            for (int i = 8; i <= 20; i++) wr(6'(i), seed[15:0], 4'h3);
            for (int i = 8; i <= 20; i++) rdc(6'(i));
            chk_ports();
        end
        // Byte strobe gates only its lane
        wr(6'h0c, 16'h1234, 4'h2);
        rdc(6'h0c);
        // Every route and both bypass settings
        for (int r = 0; r < 8; r++) begin
            wr(6'h0e, {seed[15:6], 3'b111, r[2:0]}, 4'h3);
            wr(6'h08, seed[15:0], 4'h1);
            chk_ports();
        end
        // Unmapped, unaligned and read-only places
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, k == 0 ? 8'h54 : k == 1 ? 8'hfc : 8'h21, 16'hffff, 4'h3, rd, er);
            check(er, 1);
            apb(1'b0, k == 0 ? 8'h54 : k == 1 ? 8'hfc : 8'h21, 16'h0, 4'h0, rd, er);
            check(er, 1);
            check(rd, 0);
        end
        wr(6'h20, 16'hffff, 4'h3);
        for (int i = 8; i <= 20; i++) rdc(6'(i));
        // Corrections with unity, half and one-and-a-half gain
        for (int k = 0; k < 9; k++) begin
            g = (k % 3 == 0) ? ccr_pkg::GAIN_UNITY : (k % 3 == 1) ? 24'h400000 : 24'hc00000;
            for (int c = 0; c < 2; c++) begin
                o = {seed[23:1], 1'b0};
                wr(6'(10 + 5 * c), o[23:8], 4'h3);
                wr(6'(11 + 5 * c), {o[7:0], seed[31:24]}, 4'h3);
                wr(6'(12 + 5 * c), g[23:8], 4'h3);
                wr(6'(13 + 5 * c), {g[7:0], 8'h5a}, 4'h3);
            end
            wr(6'h14, seed[15:0], 4'h3);
            pulse({seed[23:1], 1'b0}, {seed[31:9], 1'b0}, k == 8 ? 24'h7fffff : seed[27:4]);
            apb(1'b0, {ccr_pkg::IDX_STATUS, 2'b00}, 16'h0, 4'h0, rd, er);
            check(rd, {29'h0, sx});
        end
        results();
    end
endmodule
`default_nettype wire
